// >>> emd_decode.sv
// instruction decoder with length, machine cycle timing and operand results
`timescale 1ns/1ps
// How it works
// - add forms: one or two bytes, one cycle
// - logical direct,immediate is three bytes, two cycles
// - rotates through carry form nine bit loop
// - nibble swap of accumulator, one byte, one cycle
// - register and direct moves take two cycles
// - direct-direct and immediate-direct moves: three bytes
// - data pointer load is three bytes, two cycles
// - code read at accumulator plus pointer or pc
// - external transfer uses 8 or 16 bit address
// - push and pop: two bytes, two cycles
// - low digit exchange swaps only low nibbles
// - carry and/or with bit: two bytes, two cycles
// - carry to bit two cycles, reverse one
// - bit set branch clears the tested bit
// - compare branches on inequality, three bytes
// - decrement branches when result is nonzero
// - indirect jump goes to accumulator plus pointer
// - relative offset is signed from next instruction
// - page target keeps upper five next-pc bits
// - long target is full sixteen bit address
// - direct address reaches ram and special registers
// - bit address reaches flag bits and special bits
module emd_decode import emd_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // instruction issue
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] instr_addr,
  // operand state
  input wire logic [7:0] acc,
  input wire logic carry,
  input wire logic bit_val,
  input wire logic [7:0] oper,
  input wire logic [7:0] ri_byte,
  input wire logic [15:0] data_pointer,
  // timing
  output logic busy,
  output logic done,
  // decode results
  output logic [1:0] len,
  output logic [2:0] cyc,
  output logic illegal,
  output logic [7:0] acc_res,
  output logic carry_res,
  output logic [7:0] ri_res,
  output logic [7:0] dec_res,
  output logic taken,
  output logic [15:0] target,
  output logic [15:0] code_addr,
  output logic [15:0] xaddr,
  output logic xwide,
  output logic [15:0] data_pointer_res,
  output logic data_pointer_we,
  output logic [7:0] dir_addr,
  output logic dir_sfr,
  output logic [7:0] bit_byte,
  output logic [2:0] bit_idx,
  output logic bit_wr,
  output logic bit_wval
);
  logic [4:0] cls;
  logic [2:0] mode;
  logic arith;
  logic accept;
  logic [1:0] len_d;
  logic [2:0] cyc_d;
  logic ill_d;
  logic taken_d;
  logic bwr_d;
  logic bval_d;
  logic dpwe_d;
  emd_tgt_t tkind;
  logic [7:0] rel_b;
  logic [15:0] next_pc;
  logic [15:0] tgt_w;
  logic [7:0] acc_w;
  logic [7:0] ri_w;
  logic carry_w;
  emd_res_t res_d;
  emd_res_t res_r;
  emd_res_t res_nxt;
  emd_state_t state_r;
  emd_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // opcode fields and issue handshake
  assign cls = opcode[7:OPC_CLS_LSB];
  assign mode = opcode[OPC_CLS_LSB-1:0];
  assign arith = (cls == CL_ADD) || (cls == CL_ADD_WITH_CARRY) || (cls == CL_SUBTRACT_WITH_BORROW);
  assign instr_ready = (state_r == ST_IDLE);
  assign accept = instr_valid && instr_ready;
  assign next_pc = instr_addr + {14'h0000, len_d};

  // length, cycle count and branch condition per class
  always_comb begin
    len_d = LEN_1;
    cyc_d = CYC_1;
    ill_d = 1'b0;
    taken_d = 1'b0;
    bwr_d = 1'b0;
    bval_d = 1'b0;
    dpwe_d = 1'b0;
    tkind = T_REL;
    rel_b = byte2;
    case (cls)
      CL_ADD, CL_ADD_WITH_CARRY, CL_SUBTRACT_WITH_BORROW, CL_AND, CL_OR, CL_XOR: begin
        case (mode)
          M_REG, M_IND: len_d = LEN_1;
          M_DIR, M_IMM: len_d = LEN_2;
          M_DACC: begin
            len_d = LEN_2;
            ill_d = arith;
          end
          M_DIMM: begin
            len_d = LEN_3;
            cyc_d = CYC_2;
            ill_d = arith;
          end
          default: ill_d = 1'b1;
        endcase
      end
      CL_INC, CL_DEC: begin
        if (mode == M_DIR) len_d = LEN_2;
        else if (mode != M_REG && mode != M_IND && mode != M_ACC) ill_d = 1'b1;
      end
      CL_INCDP: begin
        cyc_d = CYC_2;
        dpwe_d = 1'b1;
      end
      CL_MUL, CL_DIV: cyc_d = CYC_4;
      CL_UNARY, CL_LOW_DIGIT_EXCHANGE: len_d = LEN_1;
      CL_MOVA: begin
        if (mode == M_DIR || mode == M_IMM) len_d = LEN_2;
        else if (mode != M_REG && mode != M_IND) ill_d = 1'b1;
      end
      CL_MOVR: begin
        if (mode == M_DIR) begin
          len_d = LEN_2;
          cyc_d = CYC_2;
        end else if (mode == M_IMM) len_d = LEN_2;
        else if (mode != M_ACC) ill_d = 1'b1;
      end
      CL_MOVD: begin
        len_d = LEN_2;
        case (mode)
          M_DACC: cyc_d = CYC_1;
          M_REG, M_IND: cyc_d = CYC_2;
          M_DDIR, M_DIMM: begin
            len_d = LEN_3;
            cyc_d = CYC_2;
          end
          default: ill_d = 1'b1;
        endcase
      end
      CL_MOVI: begin
        if (mode == M_DIR) begin
          len_d = LEN_2;
          cyc_d = CYC_2;
        end else if (mode == M_IMM) len_d = LEN_2;
        else if (mode != M_ACC) ill_d = 1'b1;
      end
      CL_MOVDP: begin
        len_d = LEN_3;
        cyc_d = CYC_2;
        dpwe_d = 1'b1;
      end
      CL_CODE_MEMORY_READ, CL_EXTERNAL_DATA_TRANSFER: cyc_d = CYC_2;
      CL_STACK: begin
        len_d = LEN_2;
        cyc_d = CYC_2;
      end
      CL_XCH: begin
        if (mode == M_DIR) len_d = LEN_2;
        else if (mode != M_REG && mode != M_IND) ill_d = 1'b1;
      end
      CL_BITC: begin
        if (mode >= B_AND && mode <= B_ORN) begin
          len_d = LEN_2;
          cyc_d = CYC_2;
        end else if (mode == B_MOV) len_d = LEN_2;
      end
      CL_BITD: begin
        len_d = LEN_2;
        bwr_d = (mode <= BD_CODE_MEMORY_READ);
        ill_d = (mode > BD_CODE_MEMORY_READ);
        case (mode)
          B_SET: bval_d = 1'b1;
          B_CPL: bval_d = ~bit_val;
          BD_CODE_MEMORY_READ: begin
            cyc_d = CYC_2;
            bval_d = carry;
          end
          default: bval_d = 1'b0;
        endcase
      end
      CL_PJMP, CL_PCALL: begin
        len_d = LEN_2;
        cyc_d = CYC_2;
        tkind = T_PAGE;
        taken_d = 1'b1;
      end
      CL_JMP: begin
        cyc_d = CYC_2;
        taken_d = 1'b1;
        case (mode)
          J_LONG_JUMP, J_LONG_CALL: begin
            len_d = LEN_3;
            tkind = T_LONG;
          end
          J_SHORT_RELATIVE_JUMP: len_d = LEN_2;
          J_IND: tkind = T_IND;
          J_RET, J_RETI: taken_d = 1'b0;
          default: begin
            ill_d = 1'b1;
            taken_d = 1'b0;
            cyc_d = CYC_1;
          end
        endcase
      end
      CL_JCOND: begin
        cyc_d = CYC_2;
        len_d = (mode >= C_JB) ? LEN_3 : LEN_2;
        rel_b = (mode >= C_JB) ? byte3 : byte2;
        case (mode)
          C_JZ: taken_d = (acc == 8'h00);
          C_JNZ: taken_d = (acc != 8'h00);
          C_JC: taken_d = carry;
          C_JNC: taken_d = ~carry;
          C_JB: taken_d = bit_val;
          C_JNB: taken_d = ~bit_val;
          C_JBC: begin
            taken_d = bit_val;
            bwr_d = bit_val;
          end
          default: begin
            len_d = LEN_1;
            cyc_d = CYC_1;
            ill_d = 1'b1;
          end
        endcase
      end
      CL_COMPARE_BRANCH_UNEQUAL: begin
        len_d = LEN_3;
        cyc_d = CYC_2;
        rel_b = byte3;
        case (mode)
          M_DIR: taken_d = (acc != oper);
          M_IMM: taken_d = (acc != byte2);
          M_REG, M_IND: taken_d = (oper != byte2);
          default: ill_d = 1'b1;
        endcase
      end
      CL_DECREMENT_BRANCH_NONZERO: begin
        cyc_d = CYC_2;
        taken_d = (oper != 8'h01);
        len_d = (mode == M_DIR) ? LEN_3 : LEN_2;
        rel_b = (mode == M_DIR) ? byte3 : byte2;
        ill_d = (mode != M_DIR) && (mode != M_REG);
      end
      default: ill_d = 1'b1;
    endcase
  end

  emd_target u_target (
    .kind(tkind),
    .next_pc(next_pc),
    .rel(rel_b),
    .page_hi(mode),
    .hi_byte(byte2),
    .lo_byte((cls == CL_PJMP || cls == CL_PCALL) ? byte2 : byte3),
    .acc(acc),
    .data_pointer(data_pointer),
    .target(tgt_w)
  );

  emd_accop u_accop (
    .cls(cls),
    .mode(mode),
    .acc(acc),
    .ri_byte(ri_byte),
    .carry(carry),
    .bit_val(bit_val),
    .acc_res(acc_w),
    .ri_res(ri_w),
    .carry_res(carry_w)
  );

  // result record captured at issue
  always_comb begin
    res_d.len = len_d;
    res_d.cyc = cyc_d;
    res_d.illegal = ill_d;
    res_d.acc = acc_w;
    res_d.carry = carry_w;
    res_d.ri = ri_w;
    res_d.dec = oper - 8'h01;
    res_d.taken = taken_d;
    res_d.target = tgt_w;
    res_d.code_addr = {8'h00, acc} + (mode[0] ? next_pc : data_pointer);
    res_d.xaddr = mode[0] ? data_pointer : {8'h00, oper};
    res_d.xwide = mode[0];
    res_d.data_pointer = (cls == CL_MOVDP) ? {byte2, byte3} : data_pointer + 16'h0001;
    res_d.data_pointer_we = dpwe_d;
    res_d.dir_addr = byte2;
    res_d.dir_sfr = byte2[DIR_SFR_BIT];
    res_d.bit_byte = byte2[7] ? {byte2[7:3], 3'h0} : BIT_RAM_BASE + {4'h0, byte2[6:3]};
    res_d.bit_idx = byte2[2:0];
    res_d.bit_wr = bwr_d;
    res_d.bit_wval = bval_d;
  end

  // machine cycle sequencer: next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    res_nxt = res_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          res_nxt = res_d;
          cnt_nxt = 4'(int'(cyc_d) * CLK_PER_MCYC);
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // machine cycle sequencer: registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      res_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      res_r <= res_nxt;
    end
  end

  // busy and done from the sequencer, other outputs straight from the result record
  assign busy = (state_r == ST_BUSY);
  assign done = busy && (cnt_r == 4'h1);
  assign len = res_r.len;
  assign cyc = res_r.cyc;
  assign illegal = res_r.illegal;
  assign acc_res = res_r.acc;
  assign carry_res = res_r.carry;
  assign ri_res = res_r.ri;
  assign dec_res = res_r.dec;
  assign taken = res_r.taken;
  assign target = res_r.target;
  assign code_addr = res_r.code_addr;
  assign xaddr = res_r.xaddr;
  assign xwide = res_r.xwide;
  assign data_pointer_res = res_r.data_pointer;
  assign data_pointer_we = res_r.data_pointer_we;
  assign dir_addr = res_r.dir_addr;
  assign dir_sfr = res_r.dir_sfr;
  assign bit_byte = res_r.bit_byte;
  assign bit_idx = res_r.bit_idx;
  assign bit_wr = res_r.bit_wr;
  assign bit_wval = res_r.bit_wval;

  // checks on timing and results
  a_arith_len: assert property (@(posedge mclk) disable iff (rst)
    accept && arith && mode == M_DIR |=> len == 2'h2 && cyc == 3'h1 && done)
    else $error("arith direct length or timing wrong");
  a_logic_imm: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_XOR && mode == M_DIMM |=> len == 2'h3 && !done ##1 done)
    else $error("logical direct immediate timing wrong");
  a_rlc_loop: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_UNARY && mode == U_RLC
    |=> acc_res == {$past(acc[6:0]), $past(carry)} && carry_res == $past(acc[7]))
    else $error("rotate left through carry wrong");
  a_swap_nib: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_UNARY && mode == U_SWAP |=> acc_res == {$past(acc[3:0]), $past(acc[7:4])})
    else $error("nibble swap wrong");
  a_low_digit_exchange_low: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_LOW_DIGIT_EXCHANGE
    |=> ri_res == {$past(ri_byte[7:4]), $past(acc[3:0])} && acc_res[7:4] == $past(acc[7:4]))
    else $error("low digit exchange wrong");
  a_mul_four: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_MUL |=> !done [*3] ##1 done ##1 instr_ready)
    else $error("multiply not four cycles");
  a_jbc_clear: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_JCOND && mode == C_JBC && bit_val |=> taken && bit_wr && !bit_wval)
    else $error("branch on bit did not clear bit");
  a_rel_tgt: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_JMP && mode == J_SHORT_RELATIVE_JUMP
    |=> target == $past(instr_addr) + 16'h0002 + {{8{$past(byte2[7])}}, $past(byte2)})
    else $error("relative target wrong");
  a_page_tgt: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_PJMP
    |=> target[15:11] == 5'(($past(instr_addr) + 16'h0002) >> 11)
    && target[10:8] == $past(mode) && target[7:0] == $past(byte2))
    else $error("page target left its page");
  a_decrement_branch_nonzero_take: assert property (@(posedge mclk) disable iff (rst)
    accept && cls == CL_DECREMENT_BRANCH_NONZERO && mode == M_DIR
    |=> len == 2'h3 && taken == ($past(oper) != 8'h01) ##1 done)
    else $error("decrement branch wrong");

  c_mul: cover property (@(posedge mclk) disable iff (rst) accept && cls == CL_MUL ##4 done);
  c_jbc: cover property (@(posedge mclk) disable iff (rst) accept && cls == CL_JCOND && bit_val);
  c_b2b: cover property (@(posedge mclk) disable iff (rst) done ##1 accept);
  c_compare_branch_unequal: cover property (@(posedge mclk) disable iff (rst) accept && cls == CL_COMPARE_BRANCH_UNEQUAL ##1 taken);
endmodule

// >>> emd_pkg.sv
// constants, opcode map and result record for the instruction decoder
package emd_pkg;
  // opcode layout: class in the top five bits, mode in the low three
  localparam int OPC_CLS_LSB = 3;
  localparam logic [4:0] CL_ADD = 5'h00;
  localparam logic [4:0] CL_ADD_WITH_CARRY = 5'h01;
  localparam logic [4:0] CL_SUBTRACT_WITH_BORROW = 5'h02;
  localparam logic [4:0] CL_INC = 5'h03;
  localparam logic [4:0] CL_DEC = 5'h04;
  localparam logic [4:0] CL_INCDP = 5'h05;
  localparam logic [4:0] CL_MUL = 5'h06;
  localparam logic [4:0] CL_DIV = 5'h07;
  localparam logic [4:0] CL_UNARY = 5'h08;
  localparam logic [4:0] CL_AND = 5'h09;
  localparam logic [4:0] CL_OR = 5'h0A;
  localparam logic [4:0] CL_XOR = 5'h0B;
  localparam logic [4:0] CL_MOVA = 5'h0C;
  localparam logic [4:0] CL_MOVR = 5'h0D;
  localparam logic [4:0] CL_MOVD = 5'h0E;
  localparam logic [4:0] CL_MOVI = 5'h0F;
  localparam logic [4:0] CL_MOVDP = 5'h10;
  localparam logic [4:0] CL_CODE_MEMORY_READ = 5'h11;
  localparam logic [4:0] CL_EXTERNAL_DATA_TRANSFER = 5'h12;
  localparam logic [4:0] CL_STACK = 5'h13;
  localparam logic [4:0] CL_XCH = 5'h14;
  localparam logic [4:0] CL_LOW_DIGIT_EXCHANGE = 5'h15;
  localparam logic [4:0] CL_BITC = 5'h16;
  localparam logic [4:0] CL_BITD = 5'h17;
  localparam logic [4:0] CL_PJMP = 5'h18;
  localparam logic [4:0] CL_PCALL = 5'h19;
  localparam logic [4:0] CL_JMP = 5'h1A;
  localparam logic [4:0] CL_JCOND = 5'h1B;
  localparam logic [4:0] CL_COMPARE_BRANCH_UNEQUAL = 5'h1C;
  localparam logic [4:0] CL_DECREMENT_BRANCH_NONZERO = 5'h1D;
  // operand modes
  localparam logic [2:0] M_REG = 3'h0;
  localparam logic [2:0] M_DIR = 3'h1;
  localparam logic [2:0] M_IND = 3'h2;
  localparam logic [2:0] M_IMM = 3'h3;
  localparam logic [2:0] M_ACC = 3'h4;
  localparam logic [2:0] M_DIMM = 3'h5;
  localparam logic [2:0] M_DDIR = 3'h6;
  localparam logic [2:0] M_DACC = 3'h7;
  // accumulator unary modes
  localparam logic [2:0] U_CLR = 3'h0;
  localparam logic [2:0] U_CPL = 3'h1;
  localparam logic [2:0] U_RL = 3'h2;
  localparam logic [2:0] U_RLC = 3'h3;
  localparam logic [2:0] U_RR = 3'h4;
  localparam logic [2:0] U_RRC = 3'h5;
  localparam logic [2:0] U_SWAP = 3'h6;
  // boolean modes, carry class and direct bit class
  localparam logic [2:0] B_CLR = 3'h0;
  localparam logic [2:0] B_SET = 3'h1;
  localparam logic [2:0] B_CPL = 3'h2;
  localparam logic [2:0] B_AND = 3'h3;
  localparam logic [2:0] B_ANDN = 3'h4;
  localparam logic [2:0] B_OR = 3'h5;
  localparam logic [2:0] B_ORN = 3'h6;
  localparam logic [2:0] B_MOV = 3'h7;
  localparam logic [2:0] BD_CODE_MEMORY_READ = 3'h3;
  // jump class modes
  localparam logic [2:0] J_LONG_JUMP = 3'h2;
  localparam logic [2:0] J_LONG_CALL = 3'h3;
  localparam logic [2:0] J_SHORT_RELATIVE_JUMP = 3'h4;
  localparam logic [2:0] J_IND = 3'h5;
  localparam logic [2:0] J_RET = 3'h6;
  localparam logic [2:0] J_RETI = 3'h7;
  // conditional jump modes
  localparam logic [2:0] C_JZ = 3'h0;
  localparam logic [2:0] C_JNZ = 3'h1;
  localparam logic [2:0] C_JC = 3'h2;
  localparam logic [2:0] C_JNC = 3'h3;
  localparam logic [2:0] C_JB = 3'h4;
  localparam logic [2:0] C_JNB = 3'h5;
  localparam logic [2:0] C_JBC = 3'h6;
  // lengths and machine cycle counts
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_4 = 3'h4;
  // timing: one machine cycle expressed in mclk periods
  localparam int MCLK_PERIOD_NS = 100;
  localparam int MACH_CYCLE_NS = 100;
  localparam int CLK_PER_MCYC = (MACH_CYCLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // direct and bit address map
  localparam int DIR_SFR_BIT = 7;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  typedef enum logic [1:0] {T_REL = 2'b00, T_PAGE = 2'b01, T_LONG = 2'b10, T_IND = 2'b11} emd_tgt_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_BUSY = 1'b1} emd_state_t;
  typedef struct packed {
    logic [1:0] len;
    logic [2:0] cyc;
    logic illegal;
    logic [7:0] acc;
    logic carry;
    logic [7:0] ri;
    logic [7:0] dec;
    logic taken;
    logic [15:0] target;
    logic [15:0] code_addr;
    logic [15:0] xaddr;
    logic xwide;
    logic [15:0] data_pointer;
    logic data_pointer_we;
    logic [7:0] dir_addr;
    logic dir_sfr;
    logic [7:0] bit_byte;
    logic [2:0] bit_idx;
    logic bit_wr;
    logic bit_wval;
  } emd_res_t;
endpackage

// >>> emd_accop.sv
// accumulator, low digit exchange and carry boolean unit
`timescale 1ns/1ps
module emd_accop import emd_pkg::*; (
  // operation select
  input wire logic [4:0] cls,
  input wire logic [2:0] mode,
  // operands
  input wire logic [7:0] acc,
  input wire logic [7:0] ri_byte,
  input wire logic carry,
  input wire logic bit_val,
  // results
  output logic [7:0] acc_res,
  output logic [7:0] ri_res,
  output logic carry_res
);
  // result selection, operands pass through unless the class changes them
  always_comb begin
    acc_res = acc;
    ri_res = ri_byte;
    carry_res = carry;
    case (cls)
      CL_UNARY: begin
        case (mode)
          U_CLR: acc_res = 8'h00;
          U_CPL: acc_res = ~acc;
          U_RL: acc_res = {acc[6:0], acc[7]};
          U_RLC: begin
            acc_res = {acc[6:0], carry};
            carry_res = acc[7];
          end
          U_RR: acc_res = {acc[0], acc[7:1]};
          U_RRC: begin
            acc_res = {carry, acc[7:1]};
            carry_res = acc[0];
          end
          U_SWAP: acc_res = {acc[3:0], acc[7:4]};
          default: acc_res = acc;
        endcase
      end
      CL_LOW_DIGIT_EXCHANGE: begin
        acc_res = {acc[7:4], ri_byte[3:0]};
        ri_res = {ri_byte[7:4], acc[3:0]};
      end
      CL_BITC: begin
        case (mode)
          B_CLR: carry_res = 1'b0;
          B_SET: carry_res = 1'b1;
          B_CPL: carry_res = ~carry;
          B_AND: carry_res = carry & bit_val;
          B_ANDN: carry_res = carry & ~bit_val;
          B_OR: carry_res = carry | bit_val;
          B_ORN: carry_res = carry | ~bit_val;
          default: carry_res = bit_val;
        endcase
      end
      default: carry_res = carry;
    endcase
  end
endmodule

// >>> emd_target.sv
// branch destination former for relative, page, long and indirect jumps
`timescale 1ns/1ps
module emd_target import emd_pkg::*; (
  // selection
  input wire emd_tgt_t kind,
  // address sources
  input wire logic [15:0] next_pc,
  input wire logic [7:0] rel,
  input wire logic [2:0] page_hi,
  input wire logic [7:0] hi_byte,
  input wire logic [7:0] lo_byte,
  input wire logic [7:0] acc,
  input wire logic [15:0] data_pointer,
  // destination
  output logic [15:0] target
);
  // one path per addressing kind, adders for relative and indirect only
  always_comb begin
    case (kind)
      T_REL: target = next_pc + {{8{rel[7]}}, rel};
      T_PAGE: target = {next_pc[15:11], page_hi, lo_byte};
      T_LONG: target = {hi_byte, lo_byte};
      T_IND: target = {8'h00, acc} + data_pointer;
      default: target = next_pc;
    endcase
  end
endmodule

// >>> emd_mem_model.sv
// internal data memory model answering direct and indirect reads
`timescale 1ns/1ps
module emd_mem_model (
  // addresses
  input wire logic [7:0] dir_a,
  input wire logic [7:0] ind_a,
  // read data
  output logic [7:0] dir_q,
  output logic [7:0] ind_q
);
  // each cell holds its address folded with a fixed pattern
  assign dir_q = dir_a ^ 8'h5A;
  assign ind_q = ind_a ^ 8'h5A;
endmodule

// >>> eight_bit_mcu_instr_decode_tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module eight_bit_mcu_instr_decode_tb import emd_pkg::*;;
  logic mclk, rst = 1'b1, instr_valid = 1'b0, carry = 1'b0, bit_val = 1'b0;
  logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00, acc = 8'h00;
  logic [7:0] oa = 8'h00, ia = 8'h00;
  logic [15:0] instr_addr = 16'h0000, data_pointer = 16'h0000;
  logic instr_ready, busy, done, illegal, carry_res, taken, xwide, data_pointer_we;
  logic dir_sfr, bit_wr, bit_wval;
  logic [1:0] len;
  logic [2:0] cyc, bit_idx;
  logic [7:0] oper, ri_byte, acc_res, ri_res, dec_res, dir_addr, bit_byte;
  logic [15:0] target, code_addr, xaddr, data_pointer_res;
  int err_total = 0;
  int tests_run = 0;
  // operand memory on the far side
  emd_mem_model u_mem (.dir_a(oa), .ind_a(ia), .dir_q(oper), .ind_q(ri_byte));
  emd_decode DUT (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .opcode(opcode), .byte2(byte2), .byte3(byte3),
    .instr_addr(instr_addr), .acc(acc), .carry(carry), .bit_val(bit_val),
    .oper(oper), .ri_byte(ri_byte), .data_pointer(data_pointer), .busy(busy), .done(done),
    .len(len), .cyc(cyc), .illegal(illegal), .acc_res(acc_res),
    .carry_res(carry_res), .ri_res(ri_res), .dec_res(dec_res), .taken(taken),
    .target(target), .code_addr(code_addr), .xaddr(xaddr), .xwide(xwide),
    .data_pointer_res(data_pointer_res), .data_pointer_we(data_pointer_we), .dir_addr(dir_addr),
    .dir_sfr(dir_sfr), .bit_byte(bit_byte), .bit_idx(bit_idx),
    .bit_wr(bit_wr), .bit_wval(bit_wval));
  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // issue one instruction, count clocks to done, check length and timing
  task automatic run(input logic [7:0] o, b2, b3, input logic [1:0] l, input logic [2:0] c,
    input logic il = 1'b0);
    int n;
    opcode <= o;
    byte2 <= b2;
    byte3 <= b3;
    instr_valid <= 1'b1;
    @(posedge mclk);
    for (n = 0; n < 9 && instr_ready !== 1'b1; n++) @(posedge mclk);
    instr_valid <= 1'b0;
    for (n = 1; n < 9; n++) begin
      @(posedge mclk);
      if (done === 1'b1) break;
    end
    chk(n, c, "clocks");
    chk(cyc, c, "cyc");
    chk(len, l, "len");
    chk(illegal, il, "ill");
  endtask
  task automatic t_arith();
    logic [4:0] cl [3] = '{CL_ADD, CL_ADD_WITH_CARRY, CL_SUBTRACT_WITH_BORROW};
    for (int i = 0; i < 3; i++) begin
      run({cl[i], M_REG}, 8'h00, 8'h00, LEN_1, CYC_1);
      run({cl[i], M_DIR}, 8'h90, 8'h00, LEN_2, CYC_1);
      chk({dir_sfr, dir_addr}, 9'h190, "sfr");
      run({cl[i], M_IND}, 8'h00, 8'h00, LEN_1, CYC_1);
      run({cl[i], M_IMM}, 8'h12, 8'h00, LEN_2, CYC_1);
    end
  endtask
  task automatic t_logic();
    logic [4:0] cl [3] = '{CL_AND, CL_OR, CL_XOR};
    for (int i = 0; i < 3; i++) begin
      run({cl[i], M_DIMM}, 8'h35, 8'h0F, LEN_3, CYC_2);
      run({cl[i], M_REG}, 8'h00, 8'h00, LEN_1, CYC_1);
      run({cl[i], M_IMM}, 8'h0F, 8'h00, LEN_2, CYC_1);
    end
  endtask
  task automatic t_acc();
    acc <= 8'hA5;
    run({CL_UNARY, U_RLC}, 8'h00, 8'h00, LEN_1, CYC_1);
    chk({carry_res, acc_res}, 9'h14A, "rlc");
    carry <= 1'b1;
    run({CL_UNARY, U_RRC}, 8'h00, 8'h00, LEN_1, CYC_1);
    chk({carry_res, acc_res}, 9'h1D2, "rrc");
    run({CL_UNARY, U_SWAP}, 8'h00, 8'h00, LEN_1, CYC_1);
    chk(acc_res, 8'h5A, "swap");
    acc <= 8'hC3;
    ia <= 8'h07;
    run({CL_LOW_DIGIT_EXCHANGE, M_IND}, 8'h00, 8'h00, LEN_1, CYC_1);
    chk({acc_res, ri_res}, 16'hCD53, "low_digit_exchange");
  endtask
  task automatic t_move();
    run({CL_MOVR, M_DIR}, 8'h35, 8'h00, LEN_2, CYC_2);
    chk({dir_sfr, dir_addr}, 9'h035, "ram");
    run({CL_MOVD, M_REG}, 8'h35, 8'h00, LEN_2, CYC_2);
    run({CL_MOVD, M_DDIR}, 8'h35, 8'h36, LEN_3, CYC_2);
    run({CL_MOVD, M_DIMM}, 8'h35, 8'h77, LEN_3, CYC_2);
    run({CL_MOVDP, 3'h0}, 8'hBE, 8'hEF, LEN_3, CYC_2);
    chk({data_pointer_we, data_pointer_res}, 17'h1BEEF, "dp");
    acc <= 8'hF0;
    data_pointer <= 16'h12FF;
    instr_addr <= 16'h4000;
    oa <= 8'h11;
    run({CL_CODE_MEMORY_READ, 3'h0}, 8'h00, 8'h00, LEN_1, CYC_2);
    chk(code_addr, 16'h13EF, "cdp");
    run({CL_CODE_MEMORY_READ, 3'h1}, 8'h00, 8'h00, LEN_1, CYC_2);
    chk(code_addr, 16'h40F1, "cpc");
    run({CL_EXTERNAL_DATA_TRANSFER, 3'h0}, 8'h00, 8'h00, LEN_1, CYC_2);
    chk({xwide, xaddr}, 17'h0004B, "x8");
    run({CL_EXTERNAL_DATA_TRANSFER, 3'h1}, 8'h00, 8'h00, LEN_1, CYC_2);
    chk({xwide, xaddr}, 17'h112FF, "x16");
    run({CL_STACK, 3'h0}, 8'h35, 8'h00, LEN_2, CYC_2);
    run({CL_STACK, 3'h1}, 8'h35, 8'h00, LEN_2, CYC_2);
  endtask
  task automatic t_bool();
    for (int i = 0; i < 4; i++) begin
      carry <= i < 2;
      run({CL_BITC, 3'(B_AND + i)}, 8'h13, 8'h00, LEN_2, CYC_2);
      chk(carry_res, i[0], "cbit");
      chk({bit_byte, bit_idx}, 11'h113, "bmap");
    end
    bit_val <= 1'b1;
    run({CL_BITC, B_MOV}, 8'h13, 8'h00, LEN_2, CYC_1);
    chk(carry_res, 1'b1, "bmov");
    carry <= 1'b1;
    run({CL_BITD, BD_CODE_MEMORY_READ}, 8'h8B, 8'h00, LEN_2, CYC_2);
    chk({bit_byte, bit_idx, bit_wr, bit_wval}, 13'h110F, "cmov");
  endtask
  task automatic t_branch();
    instr_addr <= 16'h2000;
    run({CL_JCOND, C_JBC}, 8'h13, 8'hF0, LEN_3, CYC_2);
    chk({taken, bit_wr, bit_wval, target}, 19'h61FF3, "jbc");
    acc <= 8'h44;
    run({CL_COMPARE_BRANCH_UNEQUAL, M_IMM}, 8'h44, 8'h10, LEN_3, CYC_2);
    chk(taken, 1'b0, "ceq");
    run({CL_COMPARE_BRANCH_UNEQUAL, M_IMM}, 8'h45, 8'h10, LEN_3, CYC_2);
    chk({taken, target}, 17'h12013, "cne");
    oa <= 8'h5B;
    run({CL_DECREMENT_BRANCH_NONZERO, M_REG}, 8'h05, 8'h00, LEN_2, CYC_2);
    chk({taken, dec_res}, 9'h000, "dz");
    oa <= 8'h5F;
    run({CL_DECREMENT_BRANCH_NONZERO, M_DIR}, 8'h5F, 8'h7F, LEN_3, CYC_2);
    chk({taken, dec_res, target}, 25'h1042082, "dnz");
    data_pointer <= 16'hFFF8;
    acc <= 8'h10;
    run({CL_JMP, J_IND}, 8'h00, 8'h00, LEN_1, CYC_2);
    chk(target, 16'h0008, "ind");
    instr_addr <= 16'h1000;
    run({CL_JMP, J_SHORT_RELATIVE_JUMP}, 8'h80, 8'h00, LEN_2, CYC_2);
    chk({taken, target}, 17'h10F82, "sj");
    instr_addr <= 16'h27FE;
    run({CL_PJMP, 3'h5}, 8'h34, 8'h00, LEN_2, CYC_2);
    chk(target, 16'h2D34, "pj");
    run({CL_PCALL, 3'h5}, 8'h34, 8'h00, LEN_2, CYC_2);
    chk(target, 16'h2D34, "pc");
    run({CL_JMP, J_LONG_JUMP}, 8'hFE, 8'hDC, LEN_3, CYC_2);
    chk(target, 16'hFEDC, "lj");
    run({CL_JMP, J_LONG_CALL}, 8'h01, 8'h23, LEN_3, CYC_2);
    chk(target, 16'h0123, "lc");
  endtask
  task automatic t_long();
    run({CL_MUL, 3'h0}, 8'h00, 8'h00, LEN_1, CYC_4);
    run({CL_DIV, 3'h0}, 8'h00, 8'h00, LEN_1, CYC_4);
    run({CL_INCDP, 3'h0}, 8'h00, 8'h00, LEN_1, CYC_2);
    run({CL_INC, M_DIR}, 8'h35, 8'h00, LEN_2, CYC_1);
    run({CL_DEC, M_REG}, 8'h00, 8'h00, LEN_1, CYC_1);
    run({CL_DECREMENT_BRANCH_NONZERO, M_IND}, 8'h05, 8'h00, LEN_2, CYC_2, 1'b1);
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({instr_ready, busy}, 2'h2, "idle");
    t_arith();
    t_logic();
    t_acc();
    t_move();
    t_bool();
    t_branch();
    t_long();
    print_verdict();
  end
endmodule
